// ===== rtl/mcrc_top.sv
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module mcrc_top
(
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  // Register port
  input  wire logic [5:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic [1:0]  reg_size_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [31:0] reg_rdata_out,
  // Transmit path events
  input  wire logic        tx_start_in,
  input  wire logic        tx_byte_in,
  input  wire logic        tx_end_in,
  input  wire logic        collision_in,
  // Verdicts to transmit path
  output logic             retry_out,
  output logic             late_collision_out,
  output logic             excess_abort_out,
  // Configuration to transmit path
  output logic      [5:0]  collision_window_bytes_out,
  output logic      [3:0]  retry_attempt_limit_out,
  // Interrupt
  output logic             irq_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed
  {
    logic [5:0]                     cwin;
    logic [3:0]                     retry;
    logic [mcrc_pkg::IRQ_W-1:0]     stat;
    logic [mcrc_pkg::IRQ_W-1:0]     en;
    logic [31:0]                    rdata;
    logic                           irq;
    mcrc_pkg::mcrc_verdict_type     vd;
  } mcrc_top_type;

  mcrc_top_type                 s_q;
  mcrc_top_type                 s_d;
  mcrc_pkg::mcrc_bus_req_type   req;
  mcrc_pkg::mcrc_tx_evt_type    evt;
  mcrc_pkg::mcrc_verdict_type   verdict;
  logic [3:0]                   attempts;
  mcrc_pkg::mcrc_tx_state_type  tx_state;

  assign req = '{wr: reg_wr_in, rd: reg_rd_in, size: reg_size_in, addr: reg_addr_in, wdata: reg_wdata_in};
  assign evt = '{tx_start: tx_start_in, tx_byte: tx_byte_in, tx_end: tx_end_in, collision: collision_in};

  mcrc_coll_judge u_judge
  (
    .core_clk_in               (core_clk_in),
    .rst_in                    (rst_in),
    .collision_window_bytes_in (s_q.cwin),
    .retry_attempt_limit_in    (s_q.retry),
    .evt_in                    (evt),
    .verdict_out               (verdict),
    .attempts_out              (attempts),
    .state_out                 (tx_state)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [31:0] cur;
    logic [31:0] nxt;
    logic        legal;
    logic [mcrc_pkg::IRQ_W-1:0] ev;
    cur   = 32'h00000000;
    nxt   = 32'h00000000;
    legal = 1'b0;
    ev    = '0;
    s_d   = s_q;

    cur[mcrc_pkg::CWIN_LSB +: mcrc_pkg::CWIN_W]   = s_q.cwin;
    cur[mcrc_pkg::RETRY_LSB +: mcrc_pkg::RETRY_W] = s_q.retry;
    legal = (req.size == mcrc_pkg::SIZE_HALF) || (req.size == mcrc_pkg::SIZE_WORD);

    // Halfword writes reach the low half, where both fields live
    nxt = cur;
    if (req.wr && legal)
    begin
      case (req.addr)
        mcrc_pkg::ADDR_CWRL:     nxt = req.wdata;
        mcrc_pkg::ADDR_CWRL_CLR: nxt = cur & ~req.wdata;
        mcrc_pkg::ADDR_CWRL_SET: nxt = cur | req.wdata;
        mcrc_pkg::ADDR_CWRL_TGL: nxt = cur ^ req.wdata;
        default:                 nxt = cur;
      endcase
    end
    s_d.cwin  = nxt[mcrc_pkg::CWIN_LSB +: mcrc_pkg::CWIN_W];
    s_d.retry = nxt[mcrc_pkg::RETRY_LSB +: mcrc_pkg::RETRY_W];

    if (req.wr && legal && req.addr == mcrc_pkg::ADDR_IRQ_EN)
    begin
      s_d.en = req.wdata[mcrc_pkg::IRQ_W-1:0];
    end

    // Sticky events; a set wins over a simultaneous clear
    ev[mcrc_pkg::IRQ_COLL]   = verdict.retry;
    ev[mcrc_pkg::IRQ_LATE]   = verdict.late;
    ev[mcrc_pkg::IRQ_EXCESS] = verdict.abort;
    s_d.stat = s_q.stat;
    if (req.wr && legal && req.addr == mcrc_pkg::ADDR_IRQ_CLR)
    begin
      s_d.stat = s_q.stat & ~req.wdata[mcrc_pkg::IRQ_W-1:0];
    end
    s_d.stat = s_d.stat | ev;
    s_d.irq  = |(s_d.stat & s_d.en);
    s_d.vd   = verdict;

    // Read data stand only in the cycle after the strobe
    s_d.rdata = 32'h00000000;
    if (req.rd && legal)
    begin
      case (req.addr)
        mcrc_pkg::ADDR_CWRL:      s_d.rdata = cur & mcrc_pkg::CWRL_MASK;
        mcrc_pkg::ADDR_IRQ_STAT:  s_d.rdata = {29'h0, s_q.stat};
        mcrc_pkg::ADDR_IRQ_EN:    s_d.rdata = {29'h0, s_q.en};
        mcrc_pkg::ADDR_TX_STAT:   s_d.rdata = {26'h0, attempts, tx_state};
        default:                  s_d.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q       <= '0;
      s_q.cwin  <= mcrc_pkg::CWIN_RESET;
      s_q.retry <= mcrc_pkg::RETRY_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign reg_rdata_out              = s_q.rdata;
  assign retry_out                  = s_q.vd.retry;
  assign late_collision_out         = s_q.vd.late;
  assign excess_abort_out           = s_q.vd.abort;
  assign collision_window_bytes_out = s_q.cwin;
  assign retry_attempt_limit_out    = s_q.retry;
  assign irq_out                    = s_q.irq;

endmodule : mcrc_top

// ===== inc/mcrc_pkg.sv
package mcrc_pkg;

  // ----------------------------------------------------------------
  // Register map (word addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0]  ADDR_CWRL      = 6'h00;
  localparam logic [5:0]  ADDR_CWRL_CLR  = 6'h01;
  localparam logic [5:0]  ADDR_CWRL_SET  = 6'h02;
  localparam logic [5:0]  ADDR_CWRL_TGL  = 6'h03;
  localparam logic [5:0]  ADDR_IRQ_STAT  = 6'h04;
  localparam logic [5:0]  ADDR_IRQ_CLR   = 6'h05;
  localparam logic [5:0]  ADDR_IRQ_EN    = 6'h06;
  localparam logic [5:0]  ADDR_TX_STAT   = 6'h07;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          CWIN_LSB       = 8;
  localparam int          CWIN_W         = 6;
  localparam int          RETRY_LSB      = 0;
  localparam int          RETRY_W        = 4;
  localparam logic [5:0]  CWIN_RESET     = 6'h37;
  localparam logic [3:0]  RETRY_RESET    = 4'hF;
  localparam logic [31:0] CWRL_MASK      = 32'h00003F0F;

  // Access size codes
  localparam logic [1:0]  SIZE_BYTE      = 2'h0;
  localparam logic [1:0]  SIZE_HALF      = 2'h1;
  localparam logic [1:0]  SIZE_WORD      = 2'h2;

  // Interrupt status bits
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_COLL       = 0;
  localparam int          IRQ_LATE       = 1;
  localparam int          IRQ_EXCESS     = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    MCRC_IDLE = 2'b00,
    MCRC_TX   = 2'b01,
    MCRC_WAIT = 2'b11
  } mcrc_tx_state_type;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [1:0]  size;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } mcrc_bus_req_type;

  typedef struct packed
  {
    logic tx_start;
    logic tx_byte;
    logic tx_end;
    logic collision;
  } mcrc_tx_evt_type;

  typedef struct packed
  {
    logic retry;
    logic late;
    logic abort;
  } mcrc_verdict_type;

endpackage : mcrc_pkg

// ===== rtl/mcrc_coll_judge.sv
`timescale 1ns/100ps
// Counts frame bytes from start of transmission and judges collisions
module mcrc_coll_judge
(
  // Clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_in,
  // Configuration
  input  wire logic [5:0]                  collision_window_bytes_in,
  input  wire logic [3:0]                  retry_attempt_limit_in,
  // Transmit events
  input  wire mcrc_pkg::mcrc_tx_evt_type   evt_in,
  // Verdicts and state
  output mcrc_pkg::mcrc_verdict_type       verdict_out,
  output logic      [3:0]                  attempts_out,
  output mcrc_pkg::mcrc_tx_state_type      state_out
);

  typedef struct packed
  {
    mcrc_pkg::mcrc_tx_state_type st;
    logic [7:0]                  bytes;
    logic [3:0]                  tries;
    mcrc_pkg::mcrc_verdict_type  vd;
  } mcrc_judge_type;

  mcrc_judge_type s_q;
  mcrc_judge_type s_d;

  always_comb
  begin
    s_d    = s_q;
    s_d.vd = '0;
    case (s_q.st)
      mcrc_pkg::MCRC_IDLE:
      begin
        if (evt_in.tx_start)
        begin
          s_d.st    = mcrc_pkg::MCRC_TX;
          s_d.bytes = 8'h00;
          s_d.tries = 4'h0;
        end
      end
      mcrc_pkg::MCRC_TX, mcrc_pkg::MCRC_WAIT:
      begin
        if (evt_in.tx_start)
        begin
          s_d.st    = mcrc_pkg::MCRC_TX;
          s_d.bytes = 8'h00;
        end
        else if (evt_in.collision && s_q.st == mcrc_pkg::MCRC_TX)
        begin
          if (s_q.bytes > {2'h0, collision_window_bytes_in})
          begin
            s_d.vd.late = 1'b1;
            s_d.st      = mcrc_pkg::MCRC_IDLE;
          end
          else if (s_q.tries >= retry_attempt_limit_in)
          begin
            s_d.vd.abort = 1'b1;
            s_d.st       = mcrc_pkg::MCRC_IDLE;
          end
          else
          begin
            s_d.vd.retry = 1'b1;
            s_d.tries    = s_q.tries + 4'h1;
            s_d.st       = mcrc_pkg::MCRC_WAIT;
          end
        end
        else if (evt_in.tx_end)
        begin
          s_d.st = mcrc_pkg::MCRC_IDLE;
        end
        else if (evt_in.tx_byte && s_q.st == mcrc_pkg::MCRC_TX && s_q.bytes != 8'hFF)
        begin
          s_d.bytes = s_q.bytes + 8'h01;
        end
      end
      default:
      begin
        s_d.st = mcrc_pkg::MCRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign verdict_out  = s_q.vd;
  assign attempts_out = s_q.tries;
  assign state_out    = s_q.st;

endmodule : mcrc_coll_judge

// ===== sim/mcrc_tx_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Transmit path and PHY event source
// ----------------------------------------
module mcrc_tx_model
(
  // Clock
  input  wire logic clk_in,
  // Transmit events
  output logic      tx_start_out,
  output logic      tx_byte_out,
  output logic      tx_end_out,
  output logic      collision_out
);
  initial {tx_start_out, tx_byte_out, tx_end_out, collision_out} = 4'h0;

  // Start, n bytes from preamble on, then collision or end
  task automatic send(input int n, input logic coll);
    @(posedge clk_in);
    tx_start_out <= 1'b1;
    @(posedge clk_in);
    tx_start_out <= 1'b0;
    tx_byte_out  <= (n > 0);
    repeat (n) @(posedge clk_in);
    if (n > 0)
      tx_byte_out <= 1'b0;
    collision_out <= coll;
    tx_end_out    <= !coll;
    @(posedge clk_in);
    {collision_out, tx_end_out} <= 2'h0;
  endtask : send
endmodule : mcrc_tx_model

// ===== sim/mcrc_top_assertions.sv
`timescale 1ns/100ps
module mcrc_chk
(
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  // Register port
  input wire logic [5:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic [1:0]  reg_size_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [31:0] reg_rdata_out,
  // Events, verdicts, fields
  input wire logic        tx_start_in,
  input wire logic        tx_byte_in,
  input wire logic        tx_end_in,
  input wire logic        collision_in,
  input wire logic        retry_out,
  input wire logic        late_collision_out,
  input wire logic        excess_abort_out,
  input wire logic [5:0]  collision_window_bytes_out,
  input wire logic [3:0]  retry_attempt_limit_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic [7:0] cnt_q;
  logic       act_q;
  logic       hit;
  logic [7:0] win;
  assign hit = collision_in && !tx_start_in && act_q;
  assign win = {2'h0, collision_window_bytes_out};
  // Frame byte count from transmission start
  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
      {cnt_q, act_q} <= 9'h000;
    else if (tx_start_in)
      {cnt_q, act_q} <= 9'h001;
    else if (collision_in || tx_end_in)
      act_q <= 1'b0;
    else if (tx_byte_in && cnt_q != 8'hFF)
      cnt_q <= cnt_q + 8'h01;
  end
  a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero");
  a_unimpl_zero: assert property ($past(reg_rd_in && reg_addr_in == 6'h00) |->
    reg_rdata_out[31:14] == 18'h0 && reg_rdata_out[7:4] == 4'h0) else $error("unused bits set");
  a_read_fields: assert property ($past(reg_rd_in && reg_addr_in == 6'h00 && reg_size_in inside {2'h1, 2'h2})
    |-> reg_rdata_out[13:8] == collision_window_bytes_out && reg_rdata_out[3:0] == retry_attempt_limit_out)
    else $error("read fields wrong");
  a_byte_ignored: assert property (reg_wr_in && reg_size_in == 2'h0 |=>
    $stable(collision_window_bytes_out) && $stable(retry_attempt_limit_out)) else $error("byte write taken");
  a_word_write: assert property (reg_wr_in && reg_addr_in == 6'h00 && reg_size_in == 2'h2 |=>
    {collision_window_bytes_out, retry_attempt_limit_out} == {$past(reg_wdata_in[13:8]), $past(reg_wdata_in[3:0])})
    else $error("word write lost");
  a_half_write: assert property (reg_wr_in && reg_addr_in == 6'h00 && reg_size_in == 2'h1 |=>
    {collision_window_bytes_out, retry_attempt_limit_out} == {$past(reg_wdata_in[13:8]), $past(reg_wdata_in[3:0])})
    else $error("half write lost");
  a_reset_fields: assert property ($past(rst_in) |-> collision_window_bytes_out == 6'h37
    && retry_attempt_limit_out == 4'hF) else $error("reset fields wrong");
  a_verdict_onehot: assert property ($onehot0({retry_out, late_collision_out, excess_abort_out}))
    else $error("two verdicts");
  a_late_window: assert property (hit && cnt_q > win |-> ##2 late_collision_out)
    else $error("late collision missed");
  a_in_window: assert property (hit && cnt_q <= win |-> ##2 (retry_out || excess_abort_out))
    else $error("in-window collision misjudged");
  c_late: cover property (late_collision_out);
  c_retry: cover property (retry_out);
  c_abort: cover property (excess_abort_out);
endmodule : mcrc_chk

bind mcrc_top mcrc_chk u_chk
(
  .core_clk_in                (core_clk_in),
  .rst_in                     (rst_in),
  .reg_addr_in                (reg_addr_in),
  .reg_wdata_in               (reg_wdata_in),
  .reg_size_in                (reg_size_in),
  .reg_wr_in                  (reg_wr_in),
  .reg_rd_in                  (reg_rd_in),
  .reg_rdata_out              (reg_rdata_out),
  .tx_start_in                (tx_start_in),
  .tx_byte_in                 (tx_byte_in),
  .tx_end_in                  (tx_end_in),
  .collision_in               (collision_in),
  .retry_out                  (retry_out),
  .late_collision_out         (late_collision_out),
  .excess_abort_out           (excess_abort_out),
  .collision_window_bytes_out (collision_window_bytes_out),
  .retry_attempt_limit_out    (retry_attempt_limit_out)
);

// ===== sim/mcrc_top_tb_top.sv
`timescale 1ns/100ps
module mcrc_top_tb_top;
  logic        clk, rst, wr_s, rd_s, ts, tb, te, tc, irq, v_r, v_l, v_a;
  logic [5:0]  addr;
  logic [1:0]  size;
  logic [31:0] wdata, rdata;
  int          err_count, samples_checked;

  mcrc_top uut (.core_clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_size_in(size), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .tx_start_in(ts),
    .tx_byte_in(tb), .tx_end_in(te), .collision_in(tc), .retry_out(v_r), .late_collision_out(v_l),
    .excess_abort_out(v_a), .collision_window_bytes_out(), .retry_attempt_limit_out(), .irq_out(irq));
  mcrc_tx_model model (.clk_in(clk), .tx_start_out(ts), .tx_byte_out(tb), .tx_end_out(te), .collision_out(tc));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic reset;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
  endtask : reset

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] s);
    @(posedge clk);
    {addr, wdata, size, wr_s} <= {a, d, s, 1'b1};
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] s = mcrc_pkg::SIZE_WORD);
    @(posedge clk);
    {addr, size, rd_s} <= {a, s, 1'b1};
    @(posedge clk);
    rd_s <= 1'b0;
    #1 cmp(rdata, e);
  endtask : rd

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 cmp({31'h0, irq}, {31'h0, e});
  endtask : irq_is

  task automatic verdict(input int n, input logic [2:0] e);
    model.send(n, 1'b1);
    repeat (4)
    begin
      @(posedge clk);
      #1;
      if (v_r || v_l || v_a)
        break;
    end
    cmp({29'h0, v_r, v_l, v_a}, {29'h0, e});
    if (!(v_r || v_l || v_a))
      close_out();
  endtask : verdict

  task automatic t_access;
    rd(mcrc_pkg::ADDR_CWRL, 32'h0000370F);
    wr(mcrc_pkg::ADDR_CWRL, 32'hFFFFFFFF, mcrc_pkg::SIZE_WORD);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00003F0F);
    wr(mcrc_pkg::ADDR_CWRL, 32'h0, mcrc_pkg::SIZE_BYTE);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00003F0F);
    wr(mcrc_pkg::ADDR_CWRL, 32'h00000A05, mcrc_pkg::SIZE_HALF);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00000A05);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00000A05, mcrc_pkg::SIZE_HALF);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00000000, mcrc_pkg::SIZE_BYTE);
    wr(mcrc_pkg::ADDR_CWRL_SET, 32'h00003000, mcrc_pkg::SIZE_HALF);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00003A05);
    wr(mcrc_pkg::ADDR_CWRL_CLR, 32'h00000005, mcrc_pkg::SIZE_WORD);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00003A00);
    wr(mcrc_pkg::ADDR_CWRL_TGL, 32'h00000101, mcrc_pkg::SIZE_WORD);
    wr(mcrc_pkg::ADDR_CWRL_SET, 32'h000000FF, mcrc_pkg::SIZE_BYTE);
    rd(mcrc_pkg::ADDR_CWRL, 32'h00003B01);
    rd(6'h08, 32'h0);
  endtask : t_access

  task automatic t_window;
    wr(mcrc_pkg::ADDR_CWRL, 32'h00000405, mcrc_pkg::SIZE_WORD);
    wr(mcrc_pkg::ADDR_IRQ_EN, 32'h0, mcrc_pkg::SIZE_WORD);
    verdict(4, 3'b100);
    verdict(5, 3'b010);
    irq_is(1'b0);
    rd(mcrc_pkg::ADDR_IRQ_STAT, 32'h3);
    wr(mcrc_pkg::ADDR_IRQ_EN, 32'h1, mcrc_pkg::SIZE_WORD);
    irq_is(1'b1);
    wr(mcrc_pkg::ADDR_IRQ_CLR, 32'h1, mcrc_pkg::SIZE_WORD);
    irq_is(1'b0);
    rd(mcrc_pkg::ADDR_IRQ_STAT, 32'h2);
  endtask : t_window

  task automatic t_abort;
    wr(mcrc_pkg::ADDR_CWRL, 32'h00003F01, mcrc_pkg::SIZE_HALF);
    verdict(3, 3'b100);
    verdict(3, 3'b001);
    rd(mcrc_pkg::ADDR_TX_STAT, 32'h00000004);
  endtask : t_abort

  initial
  begin
    {rst, wr_s, rd_s, addr, size, wdata} = {1'b1, 42'h0};
    err_count = 0;
    samples_checked = 0;
    reset();
    t_access();
    reset();
    t_window();
    reset();
    t_abort();
    close_out();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule : mcrc_top_tb_top
